// ==== design/pxg_top.sv ====
// port data, crossbar routing, pin drivers and port match
`timescale 1ns/1ps
`include "pxg_params.svh"
module pxg_top (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire pxg_pkg::pxg_bus_t BUS,
	input wire pxg_pkg::pxg_periph_t PERIPH,
	input wire pxg_pkg::pxg_opts_t OPTS,
	input wire logic MATCH_IRQ_EN,
	input wire logic [15:0] PIN_IN,
	output logic [15:0] PIN_OUT,
	output logic [15:0] PIN_OE,
	output logic [15:0] PIN_PULLUP,
	output logic [7:0] RDATA,
	output logic MATCH_EVENT,
	output logic MATCH_IRQ,
	output logic OSC_WAKE,
	output logic [15:0] PIN_ROUTED
);
	import pxg_pkg::*;

	logic [7:0] p0_lat_ff, p1_lat_ff, p0_drive_ff, p0_mask_ff, p0_skip_ff;
	logic [7:0] p0_cmp_ff, xa_ff, xb_ff, p0_kind_ff;
	logic [15:0] sync1_ff, sync2_ff;
	logic [15:0] dig_in, kind16, drive16, skip16, lat16;
	logic [15:0] nxt_out, nxt_oe, nxt_pu, nxt_routed;
	logic [7:0] nxt_rdata;
	logic nxt_match;
	logic [`PXG_NFUNC-1:0] func_en, func_val, func_od;
	logic [3:0] func_pin [`PXG_NFUNC];

	// two flip-flops before pin levels reach any logic
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sync1_ff <= 16'h0000;
			sync2_ff <= 16'h0000;
		end else begin
			sync1_ff <= PIN_IN;
			sync2_ff <= sync1_ff;
		end
	end

	// register writes
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			p0_lat_ff <= `PXG_RST_DATA;
			p1_lat_ff <= `PXG_RST_DATA;
			p0_drive_ff <= `PXG_RST_ZERO;
			p0_mask_ff <= `PXG_RST_ZERO;
			p0_skip_ff <= `PXG_RST_ZERO;
			p0_cmp_ff <= `PXG_RST_CMP;
			xa_ff <= `PXG_RST_ZERO;
			xb_ff <= `PXG_RST_ZERO;
			p0_kind_ff <= `PXG_RST_KIND;
		end else if (BUS.wr) begin
			if (BUS.addr == `PXG_ADR_P0) begin
				p0_lat_ff <= BUS.wdata;
			end else if (BUS.addr == `PXG_ADR_P1) begin
				p1_lat_ff <= BUS.wdata;
			end else if (BUS.addr == `PXG_ADR_P0_DRIVE) begin
				p0_drive_ff <= BUS.wdata;
			end else if (BUS.addr == `PXG_ADR_P0_MASK) begin
				p0_mask_ff <= BUS.wdata;
			end else if (BUS.addr == `PXG_ADR_P0_SKIP) begin
				p0_skip_ff <= BUS.wdata;
			end else if (BUS.addr == `PXG_ADR_P0_CMP) begin
				p0_cmp_ff <= BUS.wdata;
			end else if (BUS.addr == `PXG_ADR_XA) begin
				xa_ff <= BUS.wdata & `PXG_XA_MASK;
			end else if (BUS.addr == `PXG_ADR_XB) begin
				xb_ff <= BUS.wdata & `PXG_XB_MASK;
			end else if (BUS.addr == `PXG_ADR_P0_KIND) begin
				p0_kind_ff <= BUS.wdata;
			end
		end
	end

	// port 1 has no mode registers here: digital, open-drain, not skipped
	assign kind16 = {8'hff, p0_kind_ff};
	assign drive16 = {8'h00, p0_drive_ff};
	assign skip16 = {8'h00, p0_skip_ff};
	assign lat16 = {p1_lat_ff, p0_lat_ff};
	assign dig_in = sync2_ff & kind16;

	// function table in fixed priority order; smbus lines are open-drain
	always_comb begin
		func_en = '0;
		func_val = '0;
		func_od = '0;
		func_en[0] = OPTS.smbus_en;
		func_od[0] = 1'b1;
		func_en[1] = OPTS.smbus_en;
		func_od[1] = 1'b1;
		func_en[2] = xa_ff[1];
		func_val[2] = PERIPH.spi_sck;
		func_en[3] = xa_ff[1];
		func_od[3] = 1'b1; // miso is an input to the master side
		func_en[4] = xa_ff[1];
		func_val[4] = PERIPH.spi_mosi;
		func_en[5] = xa_ff[1] & OPTS.spi_nss_used;
		func_val[5] = PERIPH.spi_nss;
		func_en[6] = xa_ff[5];
		func_val[6] = PERIPH.comp_async;
		func_en[7] = xa_ff[4];
		func_val[7] = PERIPH.comp_sync;
		func_en[8] = xa_ff[3];
		func_val[8] = ~PERIPH.system_clock_div;
		func_en[9] = xa_ff[2];
		func_val[9] = PERIPH.lin_tx;
		func_en[10] = (xb_ff[1:0] != 2'b00);
		func_val[10] = PERIPH.capture[0];
		func_en[11] = xb_ff[1];
		func_val[11] = PERIPH.capture[1];
	end

	// lowest free, unskipped pin per function; uart pins reserved first
	always_comb begin
		logic [15:0] taken;
		logic [4:0] extra;
		extra = 5'h00;
		taken = skip16;
		if (xa_ff[0]) begin
			taken[`PXG_UART_TX_PIN] = 1'b1;
			taken[`PXG_UART_RX_PIN] = 1'b1;
		end
		nxt_routed = '0;
		for (int f = 0; f < `PXG_NFUNC; f++) begin
			func_pin[f] = 4'h0;
		end
		for (int f = 0; f < `PXG_NFUNC; f++) begin
			if (func_en[f]) begin
				for (int p = `PXG_NPIN - 1; p >= 0; p--) begin
					if (!taken[p]) begin
						func_pin[f] = 4'(p);
					end
				end
				if (!(&taken)) begin
					taken[func_pin[f]] = 1'b1;
					nxt_routed[func_pin[f]] = 1'b1;
				end
			end
		end
		// third capture, timers and counter input claim pins as inputs
		if (xb_ff[1:0] == 2'b11) extra = extra + 5'h01;
		if (xb_ff[5]) extra = extra + 5'h01;
		if (xb_ff[4]) extra = extra + 5'h01;
		if (xb_ff[3]) extra = extra + 5'h01;
		for (int p = 0; p < `PXG_NPIN; p++) begin
			if (!taken[p] && extra != 5'h00) begin
				taken[p] = 1'b1;
				nxt_routed[p] = 1'b1;
				extra = extra - 5'h01;
			end
		end
		if (xa_ff[0]) begin
			nxt_routed[`PXG_UART_TX_PIN] = 1'b1;
			nxt_routed[`PXG_UART_RX_PIN] = 1'b1;
		end
		if (!xb_ff[6]) nxt_routed = '0;
	end

	// per-pin drive: peripheral value or latch, then open-drain rules
	always_comb begin
		logic v;
		logic od;
		v = 1'b0;
		od = 1'b0;
		nxt_out = '0;
		nxt_oe = '0;
		nxt_pu = '0;
		for (int p = 0; p < `PXG_NPIN; p++) begin
			v = lat16[p];
			od = ~drive16[p];
			for (int f = 0; f < `PXG_NFUNC; f++) begin
				if (func_en[f] && func_pin[f] == 4'(p) && nxt_routed[p]) begin
					v = func_val[f];
					od = od | func_od[f];
				end
			end
			if (xa_ff[0] && p == `PXG_UART_TX_PIN) v = PERIPH.uart_tx;
			if (xa_ff[0] && p == `PXG_UART_RX_PIN) begin
				v = 1'b1;
				od = 1'b1;
			end
			if (xb_ff[6] && kind16[p]) begin
				nxt_out[p] = v;
				nxt_oe[p] = ~v | ~od;
				nxt_pu[p] = ~xb_ff[7] & od & v;
			end else begin
				nxt_pu[p] = ~xb_ff[7] & kind16[p];
			end
		end
	end

	// read mux: pins for plain reads, latch for read-modify-write
	always_comb begin
		nxt_rdata = 8'h00;
		if (BUS.addr == `PXG_ADR_P0) begin
			nxt_rdata = BUS.rmw ? p0_lat_ff : dig_in[7:0];
		end else if (BUS.addr == `PXG_ADR_P1) begin
			nxt_rdata = BUS.rmw ? p1_lat_ff : dig_in[15:8];
		end else if (BUS.addr == `PXG_ADR_P0_DRIVE) begin
			nxt_rdata = p0_drive_ff;
		end else if (BUS.addr == `PXG_ADR_P0_MASK) begin
			nxt_rdata = p0_mask_ff;
		end else if (BUS.addr == `PXG_ADR_P0_SKIP) begin
			nxt_rdata = p0_skip_ff;
		end else if (BUS.addr == `PXG_ADR_P0_CMP) begin
			nxt_rdata = p0_cmp_ff;
		end else if (BUS.addr == `PXG_ADR_XA) begin
			nxt_rdata = xa_ff & `PXG_XA_MASK;
		end else if (BUS.addr == `PXG_ADR_XB) begin
			nxt_rdata = xb_ff;
		end else if (BUS.addr == `PXG_ADR_P0_KIND) begin
			nxt_rdata = p0_kind_ff;
		end
	end

	assign nxt_match = ((dig_in[7:0] & p0_mask_ff) != (p0_cmp_ff & p0_mask_ff));

	// registered outputs
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PIN_OUT <= 16'h0000;
			PIN_OE <= 16'h0000;
			PIN_PULLUP <= 16'h0000;
			PIN_ROUTED <= 16'h0000;
			RDATA <= 8'h00;
			MATCH_EVENT <= 1'b0;
			MATCH_IRQ <= 1'b0;
			OSC_WAKE <= 1'b0;
		end else begin
			PIN_OUT <= nxt_out;
			PIN_OE <= nxt_oe;
			PIN_PULLUP <= nxt_pu;
			PIN_ROUTED <= nxt_routed;
			RDATA <= nxt_rdata;
			MATCH_EVENT <= nxt_match;
			MATCH_IRQ <= nxt_match & MATCH_IRQ_EN;
			OSC_WAKE <= nxt_match;
		end
	end

	a_xbar_off_quiet: assert property (@(posedge CLK) disable iff (!ARST_N)
		!xb_ff[6] |=> PIN_OE == 16'h0000) else $error("driver on with crossbar off");
	a_latch_write: assert property (@(posedge CLK) disable iff (!ARST_N)
		BUS.wr && BUS.addr == `PXG_ADR_P0 |=> p0_lat_ff == $past(BUS.wdata))
		else $error("latch not written");
	a_rsvd_zero: assert property (@(posedge CLK) disable iff (!ARST_N)
		xa_ff[7:6] == 2'b00 && xb_ff[2] == 1'b0) else $error("reserved bit set");
	a_rmw_latch: assert property (@(posedge CLK) disable iff (!ARST_N)
		BUS.rmw && BUS.addr == `PXG_ADR_P1 |=> RDATA == $past(p1_lat_ff))
		else $error("rmw read wrong");
	a_analog_zero: assert property (@(posedge CLK) disable iff (!ARST_N)
		!BUS.rmw && BUS.addr == `PXG_ADR_P0 |=> (RDATA & ~$past(p0_kind_ff)) == 8'h00)
		else $error("analog pin read nonzero");
	a_match_irq: assert property (@(posedge CLK) disable iff (!ARST_N)
		MATCH_IRQ |-> MATCH_EVENT && OSC_WAKE) else $error("irq without match");
	a_match_calc: assert property (@(posedge CLK) disable iff (!ARST_N)
		p0_mask_ff == 8'h00 |=> !MATCH_EVENT) else $error("masked match fired");
	a_pullup_off: assert property (@(posedge CLK) disable iff (!ARST_N)
		xb_ff[7] |=> PIN_PULLUP == 16'h0000) else $error("pullup while disabled");
	a_od_high: assert property (@(posedge CLK) disable iff (!ARST_N)
		xb_ff[6] && !xa_ff[0] && nxt_routed == 16'h0000 && !p0_drive_ff[0] && p0_lat_ff[0]
		|=> !PIN_OE[0]) else $error("open-drain drove high");

	c_match: cover property (@(posedge CLK) disable iff (!ARST_N) MATCH_IRQ);
	c_uart: cover property (@(posedge CLK) disable iff (!ARST_N) xa_ff[0] && xb_ff[6]);
	c_spi4: cover property (@(posedge CLK) disable iff (!ARST_N) func_en[5] && xb_ff[6]);
	c_spi3: cover property (@(posedge CLK) disable iff (!ARST_N) func_en[2] && !func_en[5]);
	c_capture3: cover property (@(posedge CLK) disable iff (!ARST_N) xb_ff[1:0] == 2'b11);

	// crossbar on, nothing skipped, pin 0 digital: the first claimant lands on pin 0
	logic lone_ctx;
	assign lone_ctx = xb_ff[6] && !OPTS.smbus_en && p0_skip_ff == 8'h00 && p0_kind_ff[0];

	a_off_unrouted: assert property (@(posedge CLK) disable iff (!ARST_N)
		!xb_ff[6] |=> PIN_ROUTED == 16'h0000)
		else $error("pin routed with crossbar off");

	a_idle_unrouted: assert property (@(posedge CLK) disable iff (!ARST_N)
		lone_ctx && xa_ff == 8'h00 && xb_ff[5:0] == 6'h00 |=> PIN_ROUTED == 16'h0000)
		else $error("pin routed with no peripheral on");

	a_skip_honoured: assert property (@(posedge CLK) disable iff (!ARST_N)
		xb_ff[6] && p0_skip_ff[0] |=> !PIN_ROUTED[0])
		else $error("skipped pin was routed");

	a_uart_fixed: assert property (@(posedge CLK) disable iff (!ARST_N)
		xb_ff[6] && xa_ff[0] |=> PIN_ROUTED[5:4] == 2'b11)
		else $error("uart pins not reserved");

	a_uart_tx_value: assert property (@(posedge CLK) disable iff (!ARST_N)
		xb_ff[6] && xa_ff[0] && p0_kind_ff[4] |=> PIN_OUT[4] == $past(PERIPH.uart_tx))
		else $error("uart transmit not on its pin");

	a_uart_rx_release: assert property (@(posedge CLK) disable iff (!ARST_N)
		xb_ff[6] && xa_ff[0] && p0_kind_ff[5] |=> !PIN_OE[5])
		else $error("uart receive pin driven");

	a_clock_inverted: assert property (@(posedge CLK) disable iff (!ARST_N)
		lone_ctx && xa_ff == 8'h08 && xb_ff[1:0] == 2'b00
		|=> PIN_ROUTED[0] && PIN_OUT[0] == !$past(PERIPH.system_clock_div))
		else $error("clock output not inverted");

	a_comp_async_pin: assert property (@(posedge CLK) disable iff (!ARST_N)
		lone_ctx && xa_ff == 8'h20 && xb_ff[1:0] == 2'b00
		|=> PIN_OUT[0] == $past(PERIPH.comp_async))
		else $error("async comparator not on pin");

	a_comp_sync_pin: assert property (@(posedge CLK) disable iff (!ARST_N)
		lone_ctx && xa_ff == 8'h10 && xb_ff[1:0] == 2'b00
		|=> PIN_OUT[0] == $past(PERIPH.comp_sync))
		else $error("sync comparator not on pin");

	a_lin_pin: assert property (@(posedge CLK) disable iff (!ARST_N)
		lone_ctx && xa_ff == 8'h04 && xb_ff[1:0] == 2'b00
		|=> PIN_OUT[0] == $past(PERIPH.lin_tx))
		else $error("lin line not on pin");

	a_spi_width: assert property (@(posedge CLK) disable iff (!ARST_N)
		lone_ctx && xa_ff == 8'h02 && xb_ff[5:0] == 6'h00
		|=> PIN_ROUTED == ($past(OPTS.spi_nss_used) ? 16'h000f : 16'h0007))
		else $error("spi pin count wrong");

	a_capture_one: assert property (@(posedge CLK) disable iff (!ARST_N)
		lone_ctx && xa_ff == 8'h00 && xb_ff[5:0] == 6'h01 |=> PIN_ROUTED == 16'h0001)
		else $error("one capture line not routed");

	a_capture_three: assert property (@(posedge CLK) disable iff (!ARST_N)
		lone_ctx && xa_ff == 8'h00 && xb_ff[5:0] == 6'h03 |=> PIN_ROUTED == 16'h0007)
		else $error("three capture lines not routed");

	a_input_claims: assert property (@(posedge CLK) disable iff (!ARST_N)
		lone_ctx && xa_ff == 8'h00 && xb_ff[5:0] == 6'h38 |=> PIN_ROUTED == 16'h0007)
		else $error("timer and count inputs not routed");

	a_push_high: assert property (@(posedge CLK) disable iff (!ARST_N)
		xb_ff[6] && !nxt_routed[0] && p0_kind_ff[0] && p0_drive_ff[0] && p0_lat_ff[0]
		|=> PIN_OE[0] && PIN_OUT[0])
		else $error("push-pull high not driven");

	a_drive_low: assert property (@(posedge CLK) disable iff (!ARST_N)
		xb_ff[6] && !nxt_routed[0] && p0_kind_ff[0] && !p0_lat_ff[0]
		|=> PIN_OE[0] && !PIN_OUT[0])
		else $error("latch zero not driven low");

	a_analog_quiet: assert property (@(posedge CLK) disable iff (!ARST_N)
		!p0_kind_ff[0] |=> !PIN_OE[0] && !PIN_PULLUP[0])
		else $error("analog pin has digital parts on");

	a_pullup_od: assert property (@(posedge CLK) disable iff (!ARST_N)
		xb_ff[6] && !xb_ff[7] && !nxt_routed[0] && p0_kind_ff[0] && !p0_drive_ff[0]
		&& p0_lat_ff[0] |=> PIN_PULLUP[0])
		else $error("open-drain pullup missing");

	a_pullup_pp: assert property (@(posedge CLK) disable iff (!ARST_N)
		xb_ff[6] && !nxt_routed[0] && p0_drive_ff[0] |=> !PIN_PULLUP[0])
		else $error("pullup on push-pull pin");

	a_port1_read: assert property (@(posedge CLK) disable iff (!ARST_N)
		!BUS.rmw && BUS.addr == `PXG_ADR_P1 |=> RDATA == $past(sync2_ff[15:8]))
		else $error("port read not from pins");

	a_ctrl_a_read: assert property (@(posedge CLK) disable iff (!ARST_N)
		BUS.addr == `PXG_ADR_XA |=> RDATA[7:6] == 2'b00)
		else $error("reserved routing bits read set");

	a_ctrl_b_write: assert property (@(posedge CLK) disable iff (!ARST_N)
		BUS.wr && BUS.addr == `PXG_ADR_XB |=> !xb_ff[2] && xb_ff[6] == $past(BUS.wdata[6]))
		else $error("routing b write wrong");

	a_wake_follows: assert property (@(posedge CLK) disable iff (!ARST_N)
		MATCH_EVENT |-> OSC_WAKE)
		else $error("match without wake");

	a_irq_gated: assert property (@(posedge CLK) disable iff (!ARST_N)
		!MATCH_IRQ_EN |=> !MATCH_IRQ)
		else $error("irq while disabled");

	a_match_rises: assert property (@(posedge CLK) disable iff (!ARST_N)
		(sync2_ff[7:0] & p0_kind_ff & p0_mask_ff) != (p0_cmp_ff & p0_mask_ff)
		|=> MATCH_EVENT)
		else $error("match event missing");
endmodule

// ==== shared/pxg_params.svh ====
// constants for the port crossbar and match block
// Notes on behaviour
// - routing_ctrl_a bits 7:6 read zero; software writes zero there.
// - bit 5 routes async comparator output, bit 4 the synchronised one.
// - bit 3 routes inverted system clock to a pin.
// - bit 2 of routing_ctrl_a routes the LIN signals.
// - SPI enable routes three or four pins, four when slave select used.
// - UART pair sits on fixed pins, port 0 bits 4 and 5 here.
// - weak pullups on unless globally disabled, or with crossbar on the pin is push-pull or driven low; never on analog pins.
// - routing_ctrl_b bit 6 enables the crossbar; resets to zero.
// - bits 5, 4, 3 route timer1, timer0 and counter-array inputs.
// - capture field routes 0, 1, 2 or 3 capture lines.
// - data register writes land in an output latch held until rewritten.
// - plain data reads return pin levels, even for peripheral pins.
// - read-modify-write reads the latch, not the pins.
// - match event when masked pins differ from masked compare value.
// - match event requests interrupt when enabled and wakes the oscillator.
// - latch 0 drives low; 1 drives high if push-pull, else floats.
// - analog pins read 0; digital pins read their level.
// - input-kind 0 makes pin analog, all digital parts off; resets ones.
// - output-drive 0 open-drain, 1 push-pull; ignored on analog pins.
// - I2C-style data and clock pins are always open-drain.
// - skip bit 1 makes the crossbar pass over that pin.
// - crossbar disabled keeps pins as inputs with drivers off.
// - each enabled peripheral takes lowest free unskipped pin, UART exempt.
`ifndef PXG_PARAMS_SVH
`define PXG_PARAMS_SVH
`define PXG_ADR_P0 8'h80
`define PXG_ADR_P1 8'h90
`define PXG_ADR_P0_DRIVE 8'ha4
`define PXG_ADR_P0_MASK 8'hc7
`define PXG_ADR_P0_SKIP 8'hd4
`define PXG_ADR_P0_CMP 8'hd7
`define PXG_ADR_XA 8'he1
`define PXG_ADR_XB 8'he2
`define PXG_ADR_P0_KIND 8'hf1
`define PXG_RST_DATA 8'hff
`define PXG_RST_ZERO 8'h00
`define PXG_RST_CMP 8'hff
`define PXG_RST_KIND 8'hff
`define PXG_XA_MASK 8'h3f
`define PXG_XB_MASK 8'hfb
`define PXG_UART_TX_PIN 4
`define PXG_UART_RX_PIN 5
`define PXG_NPIN 16
`define PXG_NFUNC 12
`endif

// ==== shared/pxg_pkg.sv ====
// types for the port crossbar and match block
package pxg_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic rmw;
	} pxg_bus_t;
	typedef struct packed {
		logic comp_async;
		logic comp_sync;
		logic system_clock_div;
		logic lin_tx;
		logic spi_sck;
		logic spi_mosi;
		logic spi_nss;
		logic uart_tx;
		logic [2:0] capture;
	} pxg_periph_t;
	typedef struct packed {
		logic spi_nss_used;
		logic smbus_en;
	} pxg_opts_t;
endpackage

// ==== testbench/pxg_pins.sv ====
// outside world at the pins: device drive wins, then outside drivers, then pullup
`timescale 1ns/1ps
module pxg_pins (
	input wire logic CLK,
	input wire logic [15:0] PIN_OUT,
	input wire logic [15:0] PIN_OE,
	input wire logic [15:0] PIN_PULLUP,
	input wire logic [15:0] EXT_EN,
	input wire logic [15:0] EXT_VAL,
	output logic [15:0] PIN_IN
);
	logic [15:0] float_ff = 16'h0000;
	// a floating pin keeps no level, so it shows a pattern that flips every cycle
	always_ff @(posedge CLK) begin
		float_ff <= ~float_ff;
	end
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (PIN_OE[i]) PIN_IN[i] = PIN_OUT[i];
			else if (EXT_EN[i]) PIN_IN[i] = EXT_VAL[i];
			else if (PIN_PULLUP[i]) PIN_IN[i] = 1'b1;
			else PIN_IN[i] = float_ff[i];
		end
	end
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the port crossbar and match block
`timescale 1ns/1ps
module testbench;
	import pxg_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	pxg_bus_t bus = '0;
	pxg_periph_t periph = '0;
	pxg_opts_t opts = '0;
	logic irq_en = 1'b0;
	logic [15:0] pin_in, pin_out, pin_oe, pin_pu, routed;
	logic [15:0] ext_en = 16'h0000;
	logic [15:0] ext_val = 16'h0000;
	logic [7:0] rdata, v;
	logic ev, irq, wake;
	logic pend = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] adr[9] = '{8'h80, 8'h90, 8'ha4, 8'hc7, 8'hd4, 8'hd7, 8'he1, 8'he2, 8'hf1};
	logic [7:0] rst[9] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff};
	int bad_count = 0;
	int n_tests = 0;
	int seed = 32'h061b;
	pxg_top dut (.CLK(clk), .ARST_N(arst_n), .BUS(bus), .PERIPH(periph), .OPTS(opts),
		.MATCH_IRQ_EN(irq_en), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
		.PIN_PULLUP(pin_pu), .RDATA(rdata), .MATCH_EVENT(ev), .MATCH_IRQ(irq),
		.OSC_WAKE(wake), .PIN_ROUTED(routed));
	pxg_pins pins (.CLK(clk), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_PULLUP(pin_pu),
		.EXT_EN(ext_en), .EXT_VAL(ext_val), .PIN_IN(pin_in));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		bus.addr = a;
		bus.wdata = d;
		bus.wr = 1'b1;
		@(negedge clk);
		bus.wr = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	// the note is queued now; the watcher pops it when the answer lands
	task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e);
		@(negedge clk);
		bus.addr = a;
		bus.rmw = m;
		bus.rd = 1'b1;
		exp_q.push_back(e);
		@(negedge clk);
		bus.rd = 1'b0;
	endtask
	always @(posedge clk) pend <= bus.rd;
	always @(negedge clk) begin
		if (pend) chk(rdata, exp_q.pop_front());
	end
	// peripheral outputs wander freely so routed pins never look right by luck
	always @(negedge clk) periph <= 11'($random(seed));
	initial begin
		repeat (4) @(posedge clk);
		@(negedge clk) arst_n = 1'b1;
		repeat (2) @(negedge clk);
		chk(pin_oe, 16'h0000);
		chk(pin_pu, 16'hffff);
		foreach (adr[i]) rd(adr[i], 1'b1, rst[i]);
		rd(8'h81, 1'b0, 8'h00);
		wr(8'he1, 8'hff);
		rd(8'he1, 1'b0, 8'h3f);
		wr(8'he2, 8'h04);
		rd(8'he2, 1'b0, 8'h00);
		wr(8'he1, 8'h00);
		wr(8'ha4, 8'hff);
		wr(8'he2, 8'h40);
		v = 8'($random(seed));
		wr(8'h80, v);
		chk(pin_out[7:0], v);
		chk(pin_oe[7:0], 8'hff);
		rd(8'h80, 1'b0, v);
		wr(8'ha4, 8'h00);
		v = 8'($random(seed));
		ext_en = 16'h00ff;
		ext_val = {8'h00, v};
		wr(8'h80, 8'hff);
		chk(pin_oe[7:0], 8'h00);
		chk(pin_pu[7:0], 8'hff);
		rd(8'h80, 1'b0, v);
		rd(8'h80, 1'b1, 8'hff);
		wr(8'hf1, 8'h0f);
		rd(8'h80, 1'b0, {4'h0, v[3:0]});
		chk(pin_pu[7:0], 8'h0f);
		wr(8'he2, 8'hc0);
		chk(pin_pu, 16'h0000);
		wr(8'hf1, 8'hff);
		wr(8'h80, 8'h00);
		chk(pin_oe[7:0], 8'hff);
		chk(pin_out[7:0], 8'h00);
		wr(8'h80, 8'hff);
		irq_en = 1'b1;
		wr(8'hc7, 8'h0f);
		wr(8'hd7, v);
		chk(ev, 1'b0);
		wr(8'hd7, v ^ 8'h10);
		chk(ev, 1'b0);
		wr(8'hd7, v ^ 8'h01);
		for (int i = 0; i < 20 && ev !== 1'b1; i++) @(negedge clk);
		if (ev !== 1'b1) begin
			bad_count++;
			stop_test();
		end
		chk(irq, 1'b1);
		chk(wake, 1'b1);
		irq_en = 1'b0;
		repeat (4) @(negedge clk);
		chk(irq, 1'b0);
		ext_en = 16'h0000;
		wr(8'hd4, 8'h01);
		wr(8'he1, 8'h08);
		wr(8'he2, 8'h40);
		chk(routed, 16'h0002);
		repeat (3) begin
			@(posedge clk);
			#1 chk(pin_out[1] ^ periph.system_clock_div, 16'h0001);
		end
		wr(8'hd4, 8'h00);
		wr(8'he1, 8'h01);
		chk(routed, 16'h0030);
		wr(8'he1, 8'h30);
		chk(routed, 16'h0003);
		wr(8'he1, 8'h04);
		chk(routed, 16'h0001);
		for (int n = 0; n < 2; n++) begin
			opts.spi_nss_used = n[0];
			wr(8'he1, 8'h02);
			chk($countones(routed), 3 + n);
		end
		wr(8'he1, 8'h00);
		for (int k = 0; k < 4; k++) begin
			wr(8'he2, 8'h40 | 8'(k));
			chk($countones(routed), k);
		end
		wr(8'he2, 8'h70);
		chk($countones(routed), 2);
		wr(8'he2, 8'h48);
		chk($countones(routed), 1);
		wr(8'he2, 8'h38);
		chk(routed, 16'h0000);
		chk(pin_oe, 16'h0000);
		stop_test();
	end
endmodule
